// *** core/cycle_counter.sv ***
// Loadable down-counter with a registered expiry pulse.
// Assumes load and cancel are synchronous one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none

module cycle_counter #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	input  wire logic             cancel,
	output var  logic             expired,
	output var  logic             running
);

	logic [WIDTH-1:0] count;
	wire              at_zero = (count == '0);

	// ---------------------------------------------------------
	// Count down, pulse once at zero
	// ---------------------------------------------------------
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			count   <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end
		else if (load)
		begin
			count   <= load_value;
			running <= 1'b1;
			expired <= 1'b0;
		end
		else if (cancel)
		begin
			running <= 1'b0;
			expired <= 1'b0;
		end
		else
		begin
			expired <= running & at_zero;
			if (running & at_zero)
				running <= 1'b0;
			else if (running)
				count <= count - 1'b1;
		end
	end

endmodule // cycle_counter

`default_nettype wire

// *** core/onboard_memory_site_decode.sv ***
// Address decode and wait-state control for the on-board memory sites.
// Assumes one local access at a time, jumpers static while accesses run.
`timescale 1ns/100ps
`default_nettype none

module onboard_memory_site_decode #(
	parameter int TIMEOUT_CYCLES = site_decode_pkg::TIMEOUT_CYCLES
) (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         req_valid,
	input  wire site_decode_pkg::access_req_s req,
	input  wire site_decode_pkg::jumper_cfg_s cfg,
	input  wire logic                         mem_protect,
	input  wire logic                         sys_cmd_start,
	input  wire logic                         sys_cmd_ack,
	input  wire logic                         timeout_clear,
	output var  site_decode_pkg::chip_enable_s chip_enable,
	output var  logic [19:0]                  dev_addr,
	output var  logic                         mem_read,
	output var  logic                         mem_write,
	output var  logic                         busy,
	output var  logic                         access_done,
	output var  logic                         access_unmapped,
	output var  logic                         access_blocked,
	output var  logic                         bus_timeout_irq
);

	typedef enum logic [1:0] {IDLE, ACCESS, FINISH} cycle_state_e;

	cycle_state_e state;
	cycle_state_e next_state;

	// ---------------------------------------------------------
	// Read-only bank base by density
	// ---------------------------------------------------------
	logic [19:0] rom_base;
	always_comb
	begin
		case (cfg.rom_density)
			site_decode_pkg::ROM_8K:  rom_base = site_decode_pkg::ROM_BASE_8K;
			site_decode_pkg::ROM_16K: rom_base = site_decode_pkg::ROM_BASE_16K;
			site_decode_pkg::ROM_32K: rom_base = site_decode_pkg::ROM_BASE_32K;
			site_decode_pkg::ROM_64K: rom_base = site_decode_pkg::ROM_BASE_64K;
			default:                  rom_base = site_decode_pkg::TOP_ADDR;
		endcase
	end

	wire rom_hit = (req.addr >= rom_base) && (req.addr <= site_decode_pkg::TOP_ADDR);

	// ---------------------------------------------------------
	// Read/write bank window, default or relocated
	// ---------------------------------------------------------
	// An erasable 2K part is only legal with the 8K decode
	wire         ram_ee_8k = cfg.ram_eeprom & (cfg.ram_density == site_decode_pkg::RAM_8K);
	logic [19:0] ram_lo;
	logic [19:0] ram_hi;
	logic        ram_window_ok;
	always_comb
	begin
		ram_lo        = site_decode_pkg::RAM_LOW_BASE;
		ram_hi        = site_decode_pkg::RAM_LOW_BASE;
		ram_window_ok = 1'b0;
		if (cfg.ram_relocate)
		begin
			case (cfg.ram_density)
				site_decode_pkg::RAM_8K:
				begin
					ram_lo        = site_decode_pkg::REL_BASE_8K;
					ram_hi        = site_decode_pkg::REL_END_8K;
					ram_window_ok = 1'b1;
				end
				site_decode_pkg::RAM_16K:
				begin
					ram_lo        = site_decode_pkg::REL_BASE_16K;
					ram_hi        = site_decode_pkg::REL_END_16K;
					ram_window_ok = 1'b1;
				end
				site_decode_pkg::RAM_32K:
				begin
					ram_lo        = site_decode_pkg::REL_BASE_32K;
					ram_hi        = site_decode_pkg::REL_END_32K;
					ram_window_ok = 1'b1;
				end
				default: ram_window_ok = 1'b0;
			endcase
		end
		else
		begin
			case (cfg.ram_density)
				site_decode_pkg::RAM_2K:
				begin
					ram_hi        = site_decode_pkg::RAM_END_2K;
					ram_window_ok = 1'b1;
				end
				site_decode_pkg::RAM_8K:
				begin
					ram_hi        = site_decode_pkg::RAM_END_8K;
					ram_window_ok = 1'b1;
				end
				site_decode_pkg::RAM_32K:
				begin
					ram_hi        = site_decode_pkg::RAM_END_32K;
					ram_window_ok = 1'b1;
				end
				default: ram_window_ok = 1'b0;
			endcase
		end
	end

	wire ram_hit = ram_window_ok && (req.addr >= ram_lo) && (req.addr <= ram_hi);

	// ---------------------------------------------------------
	// Expansion sites above the 2K/8K read/write bank; the 32K window lies inside the 32K bank
	// ---------------------------------------------------------
	logic [19:0] exp_lo;
	logic [19:0] exp_hi;
	logic        exp_window_ok;
	always_comb
	begin
		exp_lo        = site_decode_pkg::EXP_BASE_2K;
		exp_hi        = site_decode_pkg::EXP_END_2K;
		exp_window_ok = cfg.exp_present;
		case (cfg.exp_density)
			site_decode_pkg::RAM_2K:
			begin
				exp_lo = site_decode_pkg::EXP_BASE_2K;
				exp_hi = site_decode_pkg::EXP_END_2K;
			end
			site_decode_pkg::RAM_8K:
			begin
				exp_lo = site_decode_pkg::EXP_BASE_8K;
				exp_hi = site_decode_pkg::EXP_END_8K;
			end
			site_decode_pkg::RAM_32K:
			begin
				exp_lo = site_decode_pkg::EXP_BASE_32K;
				exp_hi = site_decode_pkg::EXP_END_32K;
			end
			default: exp_window_ok = 1'b0;
		endcase
	end

	wire exp_hit = exp_window_ok && (req.addr >= exp_lo) && (req.addr <= exp_hi);

	// ---------------------------------------------------------
	// Site selection, protection and gating
	// ---------------------------------------------------------
	// Read-only bank takes priority if windows ever overlap
	wire sel_rom = rom_hit;
	wire sel_ram = ram_hit & ~rom_hit;
	wire sel_exp = exp_hit & ~rom_hit & ~ram_hit;
	wire any_hit = sel_rom | sel_ram | sel_exp;

	// Protect guards read/write storage, not relocated program store
	wire rw_site       = (sel_ram & ~cfg.ram_relocate) | sel_exp;
	wire protect_block = mem_protect & rw_site;
	wire sys_block     = req.from_sysbus;
	wire grant         = any_hit & ~protect_block & ~sys_block;

	site_decode_pkg::chip_enable_s next_enable;
	assign next_enable.rom = grant & sel_rom;
	assign next_enable.ram = grant & sel_ram;
	assign next_enable.exp = grant & sel_exp;

	// Offset within the bank; erasable 2K parts wrap every 2K
	wire [19:0] bank_base = sel_rom ? rom_base : (sel_ram ? ram_lo : exp_lo);
	wire [19:0] raw_off   = req.addr - bank_base;
	wire [19:0] next_dev_addr = (sel_ram & ram_ee_8k) ? (raw_off & site_decode_pkg::EE_2K_MASK) : raw_off;

	// ---------------------------------------------------------
	// Wait-state selection per bank
	// ---------------------------------------------------------
	wire [1:0] ram_waits = cfg.ram_iram ? (cfg.ram_wait ? site_decode_pkg::WAIT_TWO : site_decode_pkg::WAIT_ONE)
	                                    : (cfg.ram_wait ? site_decode_pkg::WAIT_ONE : site_decode_pkg::WAIT_ZERO);
	wire [1:0] rom_waits = cfg.rom_wait ? site_decode_pkg::WAIT_ONE : site_decode_pkg::WAIT_ZERO;
	wire [1:0] exp_waits = cfg.exp_wait ? site_decode_pkg::WAIT_ONE : site_decode_pkg::WAIT_ZERO;
	wire [1:0] sel_waits = ~grant ? site_decode_pkg::WAIT_ZERO
	                     : (sel_rom ? rom_waits : (sel_ram ? ram_waits : exp_waits));

	wire take = (state == IDLE) & req_valid;

	wire wait_expired;
	cycle_counter #(
		.WIDTH      (site_decode_pkg::WAIT_W)
	) wait_timer (
		.clk        (clk),
		.rst        (rst),
		.load       (take),
		.load_value (sel_waits),
		.cancel     (1'b0),
		.expired    (wait_expired),
		.running    ()
	);

	// ---------------------------------------------------------
	// Access sequencing
	// ---------------------------------------------------------
	always_comb
	begin
		case (state)
			IDLE:    next_state = req_valid ? ACCESS : IDLE;
			ACCESS:  next_state = wait_expired ? FINISH : ACCESS;
			FINISH:  next_state = IDLE;
			default: next_state = IDLE;
		endcase
	end

	wire finish_now = (state == ACCESS) & wait_expired;

	always_ff @(posedge clk)
	begin
		if (rst)
			state <= IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			chip_enable <= '0;
			dev_addr    <= '0;
			mem_read    <= 1'b0;
			mem_write   <= 1'b0;
		end
		else if (take)
		begin
			chip_enable <= next_enable;
			dev_addr    <= next_dev_addr;
			mem_read    <= grant & req.read;
			mem_write   <= grant & req.write;
		end
		else if (finish_now)
		begin
			chip_enable <= '0;
			mem_read    <= 1'b0;
			mem_write   <= 1'b0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy            <= 1'b0;
			access_done     <= 1'b0;
			access_unmapped <= 1'b0;
			access_blocked  <= 1'b0;
		end
		else
		begin
			busy        <= take | (busy & ~finish_now);
			access_done <= finish_now;
			if (take)
			begin
				access_unmapped <= ~any_hit;
				access_blocked  <= any_hit & (protect_block | sys_block);
			end
		end
	end

	// ---------------------------------------------------------
	// System bus fail-safe timer
	// ---------------------------------------------------------
	wire timeout_expired;
	cycle_counter #(
		.WIDTH      (site_decode_pkg::TIMEOUT_W)
	) failsafe_timer (
		.clk        (clk),
		.rst        (rst),
		.load       (sys_cmd_start),
		.load_value (site_decode_pkg::TIMEOUT_W'(TIMEOUT_CYCLES - 2)),
		.cancel     (sys_cmd_ack),
		.expired    (timeout_expired),
		.running    ()
	);

	// Expiry wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			bus_timeout_irq <= 1'b0;
		else if (timeout_expired)
			bus_timeout_irq <= 1'b1;
		else if (timeout_clear)
			bus_timeout_irq <= 1'b0;
	end

endmodule // onboard_memory_site_decode

`default_nettype wire

// *** core/site_decode_pkg.sv ***
// Constants, types and encodings for the on-board memory site decoder.
// Assumes a 20-bit local processor address space and one 125 MHz clock.
//
// Overview of operation
// - Read-only bank ends at top, base by density
// - Read/write bank starts at zero by default
// - Relocated read/write bank sits below read-only
// - 2K erasable parts use 8K decode, aliased
// - Expansion sites decode just above 2K/8K read/write bank, inside the 32K bank
// - Jumper-selected wait states per bank
// - System bus timeout after 10 ms raises request
// - System bus never reaches on-board sites
// - Memory protect blocks read/write site access, except the relocated read/write bank

package site_decode_pkg;

	localparam int ADDR_W = 20;

	// -------------------------------------------------------------
	// Device densities selected by jumpers
	// -------------------------------------------------------------
	typedef enum logic [1:0] {ROM_8K, ROM_16K, ROM_32K, ROM_64K} rom_density_e;
	typedef enum logic [1:0] {RAM_2K, RAM_8K, RAM_16K, RAM_32K} ram_density_e;

	// -------------------------------------------------------------
	// Read-only bank bases, all ending at the top of memory
	// -------------------------------------------------------------
	localparam logic [19:0] TOP_ADDR      = 20'hFFFFF;
	localparam logic [19:0] ROM_BASE_8K   = 20'hF8000;
	localparam logic [19:0] ROM_BASE_16K  = 20'hF0000;
	localparam logic [19:0] ROM_BASE_32K  = 20'hE0000;
	localparam logic [19:0] ROM_BASE_64K  = 20'hC0000;

	// -------------------------------------------------------------
	// Read/write bank, default placement from zero
	// -------------------------------------------------------------
	localparam logic [19:0] RAM_LOW_BASE  = 20'h00000;
	localparam logic [19:0] RAM_END_2K    = 20'h01FFF;
	localparam logic [19:0] RAM_END_8K    = 20'h07FFF;
	localparam logic [19:0] RAM_END_32K   = 20'h1FFFF;

	// -------------------------------------------------------------
	// Read/write bank relocated below the read-only bank
	// -------------------------------------------------------------
	localparam logic [19:0] REL_BASE_8K   = 20'hF0000;
	localparam logic [19:0] REL_END_8K    = 20'hF7FFF;
	localparam logic [19:0] REL_BASE_16K  = 20'hE0000;
	localparam logic [19:0] REL_END_16K   = 20'hEFFFF;
	localparam logic [19:0] REL_BASE_32K  = 20'hC0000;
	localparam logic [19:0] REL_END_32K   = 20'hDFFFF;

	// -------------------------------------------------------------
	// Expansion sites just above the 2K/8K read/write bank; 32K sites in the upper half of the 32K bank
	// -------------------------------------------------------------
	localparam logic [19:0] EXP_BASE_2K   = 20'h02000;
	localparam logic [19:0] EXP_END_2K    = 20'h03FFF;
	localparam logic [19:0] EXP_BASE_8K   = 20'h08000;
	localparam logic [19:0] EXP_END_8K    = 20'h0FFFF;
	localparam logic [19:0] EXP_BASE_32K  = 20'h10000;
	localparam logic [19:0] EXP_END_32K   = 20'h1FFFF;

	// Offset mask of a 2K x 8 erasable part, aliased sixteen times in the 20'h08000 window
	localparam logic [19:0] EE_2K_MASK    = 20'h007FF;

	// -------------------------------------------------------------
	// Wait states
	// -------------------------------------------------------------
	localparam int          WAIT_W        = 2;
	localparam logic [1:0]  WAIT_ZERO     = 2'h0;
	localparam logic [1:0]  WAIT_ONE      = 2'h1;
	localparam logic [1:0]  WAIT_TWO      = 2'h2;

	// -------------------------------------------------------------
	// System bus fail-safe timeout
	// -------------------------------------------------------------
	localparam int          CLK_MHZ       = 125;
	localparam int          TIMEOUT_MS    = 10;
	localparam int          TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * 1000 * CLK_MHZ / 1000;
	localparam int          TIMEOUT_W     = 21;

	// -------------------------------------------------------------
	// Carriers
	// -------------------------------------------------------------
	typedef struct packed {
		logic [19:0] addr;
		logic        read;
		logic        write;
		logic        from_sysbus;
	} access_req_s;

	typedef struct packed {
		rom_density_e rom_density;
		ram_density_e ram_density;
		logic         ram_relocate;
		logic         ram_eeprom;
		logic         ram_iram;
		ram_density_e exp_density;
		logic         exp_present;
		logic         rom_wait;
		logic         ram_wait;
		logic         exp_wait;
	} jumper_cfg_s;

	typedef struct packed {
		logic rom;
		logic ram;
		logic exp;
	} chip_enable_s;

endpackage

// *** testbench/onboard_memory_site_decode_tb.sv ***
// Self-checking bench for the memory site decoder.
// Assumes a short timeout parameter and a system bus responder model.
`timescale 1ns/100ps
`default_nettype none

module onboard_memory_site_decode_tb;
	localparam int TMO = 20;

	logic                          clk = 0;
	logic                          rst = 1;
	logic                          req_valid = 0;
	site_decode_pkg::access_req_s  req = '0;
	site_decode_pkg::jumper_cfg_s  cfg = '0;
	logic                          mem_protect = 0;
	logic                          sys_cmd_start = 0;
	logic                          timeout_clear = 0;
	logic                          ack_en = 0;
	logic                          sys_cmd_ack;
	site_decode_pkg::chip_enable_s chip_enable;
	logic [19:0]                   dev_addr;
	logic                          mem_read, mem_write, busy, access_done;
	logic                          access_unmapped, access_blocked, bus_timeout_irq;
	int                            error_cnt = 0;
	int                            samples_checked = 0;

	onboard_memory_site_decode #(.TIMEOUT_CYCLES(TMO)) i_dut (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req(req), .cfg(cfg), .mem_protect(mem_protect), .sys_cmd_start(sys_cmd_start),
		.sys_cmd_ack(sys_cmd_ack), .timeout_clear(timeout_clear), .chip_enable(chip_enable),
		.dev_addr(dev_addr), .mem_read(mem_read), .mem_write(mem_write), .busy(busy),
		.access_done(access_done), .access_unmapped(access_unmapped), .access_blocked(access_blocked),
		.bus_timeout_irq(bus_timeout_irq));

	sys_bus_responder #(.ACK_DELAY(5)) i_sys (.clk(clk), .rst(rst), .ack_enable(ack_en),
		.sys_cmd_start(sys_cmd_start), .sys_cmd_ack(sys_cmd_ack));

	initial forever #4 clk = ~clk;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic conclude();
		if (error_cnt == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic pulse(ref logic s);
		@(posedge clk);
		#1 s = 1;
		@(posedge clk);
		#1 s = 0;
	endtask

	// One access; b marks a matched but blocked access
	task automatic access(input logic [19:0] a, input logic wr, input logic sys, input logic [2:0] ce,
		input int w, input logic [19:0] off, input logic b);
		int k;
		int n;
		int nb;
		logic [2:0] seen;
		logic [1:0] rw;
		n = 0;
		nb = 0;
		seen = 3'h0;
		rw = 2'h0;
		@(posedge clk);
		#1 req = '{a, !wr, wr, sys};
		req_valid = 1;
		@(posedge clk);
		#1 req_valid = 0;
		for (k = 0; k < 8 && access_done !== 1'h1; k++)
		begin
			if (chip_enable !== 3'h0)
			begin
				n++;
				seen = chip_enable;
			end
			if (busy === 1'h1)
				nb++;
			rw = rw | {mem_read, mem_write};
			@(posedge clk);
			#1;
		end
		if (k == 8)
		begin
			check(0, 1);
			conclude();
		end
		check(seen, ce);
		check(n, (ce != 0) ? w + 2 : 0);
		check(k, w + 2);
		check({access_unmapped, access_blocked}, (ce != 0) ? 0 : (b ? 1 : 2));
		check(nb, w + 2);
		check(rw, (ce != 0) ? {!wr, wr} : 2'h0);
		if (ce != 0)
			check(dev_addr, off);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic rom_sites();
		logic [19:0] b[4] = '{20'hF8000, 20'hF0000, 20'hE0000, 20'hC0000};
		cfg = '0;
		cfg.rom_wait = 1;
		for (int i = 0; i < 4; i++)
		begin
			cfg.rom_density = site_decode_pkg::rom_density_e'(i);
			access(b[i], 0, 0, 3'h4, 1, 20'h0, 0);
			access(20'hFFFFF, 0, 0, 3'h4, 1, 20'hFFFFF - b[i], 0);
			access(b[i] - 20'h1, 0, 0, 3'h0, 0, 20'h0, 0);
		end
	endtask

	task automatic ram_sites();
		logic [19:0] e[3] = '{20'h01FFF, 20'h07FFF, 20'h1FFFF};
		int d[3] = '{0, 1, 3};
		cfg = '0;
		cfg.ram_wait = 1;
		for (int j = 0; j < 3; j++)
		begin
			cfg.ram_density = site_decode_pkg::ram_density_e'(d[j]);
			access(20'h0, 1, 0, 3'h2, 1, 20'h0, 0);
			access(e[j], 1, 0, 3'h2, 1, e[j], 0);
			access(e[j] + 20'h1, 1, 0, 3'h0, 0, 20'h0, 0);
		end
		cfg.ram_iram = 1;
		cfg.ram_density = site_decode_pkg::RAM_8K;
		for (int j = 0; j < 2; j++)
		begin
			cfg.ram_wait = j[0];
			access(20'h10, 0, 0, 3'h2, j + 1, 20'h10, 0);
		end
		cfg.ram_density = site_decode_pkg::RAM_16K;
		access(20'h10, 0, 0, 3'h0, 0, 20'h0, 0);
	endtask

	task automatic reloc_sites();
		logic [19:0] b[3] = '{20'hF0000, 20'hE0000, 20'hC0000};
		logic [19:0] e[3] = '{20'hF7FFF, 20'hEFFFF, 20'hDFFFF};
		cfg = '0;
		cfg.ram_relocate = 1;
		for (int i = 0; i < 3; i++)
		begin
			cfg.rom_density = site_decode_pkg::rom_density_e'(i);
			cfg.ram_density = site_decode_pkg::ram_density_e'(i + 1);
			access(b[i], 0, 0, 3'h2, 0, 20'h0, 0);
			access(e[i], 0, 0, 3'h2, 0, e[i] - b[i], 0);
			access(e[i] + 20'h1, 0, 0, 3'h4, 0, 20'h0, 0);
			access(b[i] - 20'h1, 0, 0, 3'h0, 0, 20'h0, 0);
		end
		cfg.rom_density = site_decode_pkg::ROM_8K;
		cfg.ram_density = site_decode_pkg::RAM_8K;
		cfg.ram_eeprom = 1;
		for (int k = 0; k < 4; k++)
			access(20'hF0005 + (20'(k) << 11), 0, 0, 3'h2, 0, 20'h5, 0);
	endtask

	task automatic exp_sites();
		logic [19:0] b[3] = '{20'h02000, 20'h08000, 20'h10000};
		logic [19:0] e[3] = '{20'h03FFF, 20'h0FFFF, 20'h1FFFF};
		int d[3] = '{0, 1, 3};
		cfg = '0;
		cfg.exp_present = 1;
		cfg.exp_wait = 1;
		for (int j = 0; j < 3; j++)
		begin
			cfg.exp_density = site_decode_pkg::ram_density_e'(d[j]);
			access(b[j], 1, 0, 3'h1, 1, 20'h0, 0);
			access(e[j], 1, 0, 3'h1, 1, e[j] - b[j], 0);
			access(e[j] + 20'h1, 1, 0, 3'h0, 0, 20'h0, 0);
		end
		cfg.exp_present = 0;
		access(20'h10000, 1, 0, 3'h0, 0, 20'h0, 0);
		cfg.exp_present = 1;
		cfg.exp_density = site_decode_pkg::RAM_16K;
		access(20'h08000, 1, 0, 3'h0, 0, 20'h0, 0);
	endtask

	task automatic protect_sysbus();
		cfg = '0;
		cfg.exp_present = 1;
		mem_protect = 1;
		access(20'h00010, 1, 0, 3'h0, 0, 20'h0, 1);
		access(20'h02010, 0, 0, 3'h0, 0, 20'h0, 1);
		access(20'hFFFF0, 0, 0, 3'h4, 0, 20'h7FF0, 0);
		cfg.ram_relocate = 1;
		cfg.ram_density = site_decode_pkg::RAM_8K;
		access(20'hF0010, 0, 0, 3'h2, 0, 20'h10, 0);
		mem_protect = 0;
		access(20'hF0010, 0, 1, 3'h0, 0, 20'h0, 1);
		access(20'hFFFF0, 0, 1, 3'h0, 0, 20'h0, 1);
	endtask

	task automatic timeout_check();
		int n;
		ack_en = 1;
		pulse(sys_cmd_start);
		repeat (TMO + 10) @(posedge clk);
		#1 check(bus_timeout_irq, 0);
		ack_en = 0;
		for (int r = 0; r < 2; r++)
		begin
			// Second pass restarts a running timer
			if (r == 1)
			begin
				pulse(sys_cmd_start);
				repeat (10) @(posedge clk);
			end
			pulse(sys_cmd_start);
			for (n = 0; n < 40 && bus_timeout_irq !== 1'h1; n++)
				@(posedge clk) #1;
			check(n >= TMO - 1 && n <= TMO + 1, 1);
			if (n == 40)
				conclude();
			repeat (3) @(posedge clk);
			#1 check(bus_timeout_irq, 1);
			pulse(timeout_clear);
			check(bus_timeout_irq, 0);
		end
	endtask

	initial
	begin
		repeat (2) @(posedge clk);
		#1 rst = 0;
		rom_sites();
		ram_sites();
		reloc_sites();
		exp_sites();
		protect_sysbus();
		timeout_check();
		conclude();
	end
endmodule // onboard_memory_site_decode_tb
`default_nettype wire

// *** testbench/site_decode_chk.sv ***
// Concurrent checks on the ports of the memory site decoder.
// Assumes binding into the decoder top module.
`timescale 1ns/100ps
`default_nettype none

module site_decode_chk #(
	parameter int TIMEOUT_CYCLES = 20
) (
	input wire logic                          clk,
	input wire logic                          rst,
	input wire logic                          req_valid,
	input wire site_decode_pkg::access_req_s  req,
	input wire site_decode_pkg::jumper_cfg_s  cfg,
	input wire logic                          mem_protect,
	input wire logic                          sys_cmd_start,
	input wire logic                          sys_cmd_ack,
	input wire logic                          timeout_clear,
	input wire site_decode_pkg::chip_enable_s chip_enable,
	input wire logic                          busy,
	input wire logic                          access_done,
	input wire logic                          access_unmapped,
	input wire logic                          access_blocked,
	input wire logic                          bus_timeout_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	localparam int T_LO = TIMEOUT_CYCLES - 1;
	localparam int T_HI = TIMEOUT_CYCLES + 2;

	wire take = req_valid && !busy && !access_done;
	// Read-only bank grows down from the top by density
	wire [19:0] rom_base = 20'h0 - (20'h08000 << cfg.rom_density);
	wire rom_hit = req.addr >= rom_base;

	int unsigned tmo_cnt;

	always_ff @(posedge clk)
	begin
		if (rst || sys_cmd_ack)
			tmo_cnt <= 0;
		else if (sys_cmd_start)
			tmo_cnt <= 1;
		else if (tmo_cnt != 0)
			tmo_cnt <= tmo_cnt + 1;
	end

	sequence s_rom_take;
		take && rom_hit && cfg.rom_wait && !req.from_sysbus;
	endsequence

	sequence s_rom_hold;
		chip_enable.rom [*3] ##1 (access_done && !chip_enable.rom);
	endsequence

	a_rom_top_bank: assert property (take && rom_hit && !req.from_sysbus |=> chip_enable == 3'h4)
		else $error("read-only bank not selected");
	a_rom_wait_one: assert property (s_rom_take |=> s_rom_hold)
		else $error("read-only access length wrong");
	a_ram_low_bank: assert property (take && !req.from_sysbus && !mem_protect && !cfg.ram_relocate
		&& cfg.ram_density == site_decode_pkg::RAM_32K && req.addr <= 20'h1FFFF |=> chip_enable.ram)
		else $error("read/write bank not selected");
	a_sysbus_no_ce: assert property (take && req.from_sysbus && rom_hit
		|=> (chip_enable == 3'h0 && access_blocked) [*2] ##1 access_done)
		else $error("system bus reached a site");
	a_protect_block: assert property (take && mem_protect && !cfg.ram_relocate && !req.from_sysbus
		&& req.addr < 20'h02000 |=> !chip_enable.ram && !chip_enable.exp)
		else $error("protected site enabled");
	a_gap_no_ce: assert property (take && !rom_hit && !cfg.ram_relocate && req.addr >= 20'h20000
		|=> chip_enable == 3'h0 && access_unmapped)
		else $error("unmapped address enabled a site");
	a_unmapped_idle: assert property (access_unmapped |-> chip_enable == 3'h0)
		else $error("chip enable with unmapped flag");
	a_irq_window: assert property ($rose(bus_timeout_irq) |-> tmo_cnt >= T_LO && tmo_cnt <= T_HI)
		else $error("timeout request at wrong time");
	a_irq_sticky: assert property (bus_timeout_irq && !timeout_clear |=> bus_timeout_irq)
		else $error("timeout request dropped");
endmodule // site_decode_chk

bind onboard_memory_site_decode site_decode_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (
	.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .cfg(cfg), .mem_protect(mem_protect),
	.sys_cmd_start(sys_cmd_start), .sys_cmd_ack(sys_cmd_ack), .timeout_clear(timeout_clear),
	.chip_enable(chip_enable), .busy(busy), .access_done(access_done), .access_unmapped(access_unmapped),
	.access_blocked(access_blocked), .bus_timeout_irq(bus_timeout_irq));
`default_nettype wire

// *** testbench/sys_bus_responder.sv ***
// Model of a system bus device that answers commands after a delay.
// Assumes start is a one-cycle pulse; at most one answer per command.
`timescale 1ns/100ps
`default_nettype none

module sys_bus_responder #(
	parameter int ACK_DELAY = 5
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ack_enable,
	input  wire logic sys_cmd_start,
	output var  logic sys_cmd_ack
);
	int left;

	// Silent device when ack_enable is low
	always_ff @(posedge clk)
	begin
		sys_cmd_ack <= 1'h0;
		if (rst)
			left <= 0;
		else if (sys_cmd_start)
			left <= ACK_DELAY;
		else if (left != 0)
		begin
			left        <= left - 1;
			sys_cmd_ack <= ack_enable && left == 1;
		end
	end
endmodule // sys_bus_responder
`default_nettype wire
